//--- verilog/reset_cause_and_nmi_control.v
// Behaviour
// - IO and core supply power-on events set bits 31 and 30.
// - Software writing one to a cause flag only sets the flag.
// - Primary boot config bad, secondary used: set bit 27.
// - Boot configuration failure sets bit 26.
// - NVM lifetime alert sets bit 25; end-of-life sets bit 24.
// - Battery-domain power-on sets bit 17; exit from battery sets bit 16.
// - Deep Sleep entry sets bit 10.
// - Mismatch, pin, software, deadman, watchdog resets set bits 9,7,6,5,4.
// - Sleep and idle wake flags; writing one invokes no mode.
// - Brown-out sets bit 1; power-on sets bit 0.
// - Supply, sleep, brown-out, power-on flags stay set until cleared.
// - Trigger and NMI control writes ignored unless unlock sequence done.
// - After trigger written, a read of trigger register issues system reset.
// - Writing one to software NMI bit raises an NMI; zero does nothing.
// - Deadman timeout or write sets bit 25, raises NMI, starts counter.
// - Watchdog run timeout or write sets bit 24, raises NMI, starts counter.
// - Generic event sets bit 19, low voltage sets bit 18, both raise NMI.
// - Clock failure sets bit 17 and raises NMI; write sets bit 17 and raises NMI, no counter.
// - Watchdog timeout in Sleep sets bit 16 and wakes; write raises NMI.
// - Counter loads reload field and decrements each clock; zero resets.
// - Clearing both counting NMI flags (bits 25 and 24) before zero abandons the count.
// - Reload of zero gives reset in the same cycle as the NMI.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_map.vh"

module reset_cause_and_nmi_control (
	input  wire        CLOCK_IN,
	input  wire        RST_IN,
	input  wire        WB_CYC_IN,
	input  wire        WB_STB_IN,
	input  wire        WB_WE_IN,
	input  wire [3:0]  WB_ADR_IN,
	input  wire [3:0]  WB_SEL_IN,
	input  wire [31:0] WB_DAT_IN,
	output reg  [31:0] WB_DAT_OUT,
	output reg         WB_ACK_OUT,
	input  wire        IO_POR_EVT_IN,
	input  wire        CORE_POR_EVT_IN,
	input  wire        BOOT_CFG_ERR_EVT_IN,
	input  wire        BOOT_CFG_FAIL_EVT_IN,
	input  wire        NVM_LTA_EVT_IN,
	input  wire        NVM_EOL_EVT_IN,
	input  wire        BAT_POR_EVT_IN,
	input  wire        BAT_EXIT_EVT_IN,
	input  wire        DEEP_SLEEP_EVT_IN,
	input  wire        CFG_MISMATCH_EVT_IN,
	input  wire        EXT_PIN_RESET_EVT_IN,
	input  wire        DEADMAN_RESET_EVT_IN,
	input  wire        WATCHDOG_RESET_EVT_IN,
	input  wire        SLEEP_WAKE_EVT_IN,
	input  wire        IDLE_WAKE_EVT_IN,
	input  wire        BROWNOUT_EVT_IN,
	input  wire        POR_EVT_IN,
	input  wire        DEADMAN_NMI_EVT_IN,
	input  wire        WDT_RUN_NMI_EVT_IN,
	input  wire        GENERIC_NMI_EVT_IN,
	input  wire        LOW_VOLT_EVT_IN,
	input  wire        CLK_FAIL_EVT_IN,
	input  wire        WDT_SLEEP_EVT_IN,
	output reg         NMI_REQ_OUT,
	output reg         SW_NMI_PULSE_OUT,
	output reg         SLEEP_WAKE_OUT,
	output reg         SYS_RESET_OUT,
	output reg         SW_RESET_OUT,
	output reg         NMI_RESET_OUT,
	output reg         UNLOCKED_OUT
);

	reg  [31:0] cause;
	reg  [31:0] nmi_ctl;
	reg         sw_reset_trigger_armed;
	reg  [1:0]  unlock_state;
	reg  [15:0] nmi_count;
	reg         count_run;
	reg  [31:0] next_cause;
	reg  [31:0] next_nmi;
	reg  [31:0] wmask;
	reg  [31:0] hw_cause;
	reg  [31:0] rdata;

	localparam [1:0] UL_IDLE = 2'h0;
	localparam [1:0] UL_KEY1 = 2'h1;
	localparam [1:0] UL_OPEN = 2'h2;

	wire        req     = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	wire        wr      = req & WB_WE_IN;
	wire        rd      = req & ~WB_WE_IN;
	wire [1:0]  widx    = WB_ADR_IN[3:2];
	wire        open_ok = (unlock_state == UL_OPEN);
	wire        ctl_wr  = wr & (widx == `ADDR_NMICTL) & open_ok;
	wire        rst_wr  = wr & (widx == `ADDR_SW_RESET_TRIGGER) & open_ok;
	wire [31:0] wdata   = WB_DAT_IN & wmask;
	// Counting sources: deadman or watchdog-run flags, hardware or written
	wire        cnt_src = nmi_ctl[`NMI_DEADMAN] | nmi_ctl[`NMI_WDT_RUN];
	wire        cnt_new = (DEADMAN_NMI_EVT_IN & ~nmi_ctl[`NMI_DEADMAN])
		| (WDT_RUN_NMI_EVT_IN & ~nmi_ctl[`NMI_WDT_RUN])
		| (ctl_wr & wdata[`NMI_DEADMAN] & ~nmi_ctl[`NMI_DEADMAN])
		| (ctl_wr & wdata[`NMI_WDT_RUN] & ~nmi_ctl[`NMI_WDT_RUN]);
	wire        sw_nmi  = ctl_wr & wdata[`NMI_SW_TRIG];

	// Byte lane mask from the select lines
	always @* begin
		wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
	end

	// Hardware event vector aligned to the cause register layout
	always @* begin
		hw_cause = 32'h00000000;
		hw_cause[`CAUSE_IO_POR]     = IO_POR_EVT_IN;
		hw_cause[`CAUSE_CORE_POR]   = CORE_POR_EVT_IN;
		hw_cause[`CAUSE_BOOT_CONFIG_VALUE_ERR]   = BOOT_CFG_ERR_EVT_IN;
		hw_cause[`CAUSE_BOOT_CONFIG_VALUE_FAIL]  = BOOT_CFG_FAIL_EVT_IN;
		hw_cause[`CAUSE_NVM_LTA]    = NVM_LTA_EVT_IN;
		hw_cause[`CAUSE_NVM_EOL]    = NVM_EOL_EVT_IN;
		hw_cause[`CAUSE_BAT_POR]    = BAT_POR_EVT_IN;
		hw_cause[`CAUSE_BAT_EXIT]   = BAT_EXIT_EVT_IN;
		hw_cause[`CAUSE_DEEP_SLEEP] = DEEP_SLEEP_EVT_IN;
		hw_cause[`CAUSE_CFG_MISM]   = CFG_MISMATCH_EVT_IN;
		hw_cause[`CAUSE_EXT_PIN]    = EXT_PIN_RESET_EVT_IN;
		hw_cause[`CAUSE_SW_RESET]   = SW_RESET_OUT;
		hw_cause[`CAUSE_DEADMAN]    = DEADMAN_RESET_EVT_IN;
		hw_cause[`CAUSE_WATCHDOG]   = WATCHDOG_RESET_EVT_IN;
		hw_cause[`CAUSE_SLEEP]      = SLEEP_WAKE_EVT_IN;
		hw_cause[`CAUSE_IDLE]       = IDLE_WAKE_EVT_IN;
		hw_cause[`CAUSE_BROWNOUT]   = BROWNOUT_EVT_IN;
		hw_cause[`CAUSE_POR]        = POR_EVT_IN;
	end

	// Cause register: writes store only, hardware set wins over a clear
	always @* begin
		next_cause = cause;
		if (wr && widx == `ADDR_CAUSE)
			next_cause = (cause & ~wmask) | wdata;
		next_cause = (next_cause | hw_cause) & `CAUSE_IMPL_MASK;
	end

	// NMI control: flags set by events or written ones, count field stored
	always @* begin
		next_nmi = nmi_ctl;
		if (ctl_wr)
			next_nmi = (nmi_ctl & ~wmask) | wdata;
		next_nmi[`NMI_SW_TRIG] = 1'b0;
		if (DEADMAN_NMI_EVT_IN)
			next_nmi[`NMI_DEADMAN] = 1'b1;
		if (WDT_RUN_NMI_EVT_IN)
			next_nmi[`NMI_WDT_RUN] = 1'b1;
		if (GENERIC_NMI_EVT_IN)
			next_nmi[`NMI_GENERIC] = 1'b1;
		if (LOW_VOLT_EVT_IN)
			next_nmi[`NMI_LOW_VOLT] = 1'b1;
		if (CLK_FAIL_EVT_IN)
			next_nmi[`NMI_CLK_FAIL] = 1'b1;
		if (WDT_SLEEP_EVT_IN)
			next_nmi[`NMI_WDT_SLEEP] = 1'b1;
		next_nmi = next_nmi & (`NMI_FLAG_MASK | 32'h0000FFFF);
	end

	// Read data mux; trigger register reads back as zero
	always @* begin
		case (widx)
			`ADDR_CAUSE:  rdata = cause;
			`ADDR_NMICTL: rdata = nmi_ctl;
			`ADDR_UNLOCK: rdata = {31'h00000000, open_ok};
			default:      rdata = 32'h00000000;
		endcase
	end

	// Bus slave: one wait-free ack per request
	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else begin
			WB_ACK_OUT <= req;
			if (rd)
				WB_DAT_OUT <= rdata;
		end
	end

	// Unlock sequencer: two keys open writes; any trigger or control write relocks
	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			unlock_state <= UL_IDLE;
		end else if (wr && widx == `ADDR_UNLOCK) begin
			case (unlock_state)
				UL_IDLE: unlock_state <= (WB_DAT_IN == `UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
				UL_KEY1: unlock_state <= (WB_DAT_IN == `UNLOCK_KEY2) ? UL_OPEN : UL_IDLE;
				UL_OPEN: unlock_state <= UL_IDLE;
				default: unlock_state <= UL_IDLE;
			endcase
		end else if (wr && (widx == `ADDR_SW_RESET_TRIGGER || widx == `ADDR_NMICTL)) begin
			unlock_state <= UL_IDLE;
		end else if (unlock_state == UL_KEY1 && wr) begin
			unlock_state <= UL_IDLE;
		end
	end

	// Registers, software reset trigger and NMI reset counter
	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cause            <= `CAUSE_RESET_VAL;
			nmi_ctl          <= `NMI_RESET_VAL;
			sw_reset_trigger_armed      <= 1'b0;
			nmi_count        <= 16'h0000;
			count_run        <= 1'b0;
			NMI_REQ_OUT      <= 1'b0;
			SW_NMI_PULSE_OUT <= 1'b0;
			SLEEP_WAKE_OUT   <= 1'b0;
			SYS_RESET_OUT    <= 1'b0;
			SW_RESET_OUT     <= 1'b0;
			NMI_RESET_OUT    <= 1'b0;
			UNLOCKED_OUT     <= 1'b0;
		end else begin
			cause        <= next_cause;
			nmi_ctl      <= next_nmi;
			UNLOCKED_OUT <= open_ok;
			// Armed trigger fires a reset on any read of its register
			if (rst_wr && WB_SEL_IN[0] && WB_DAT_IN[`SW_RESET_TRIGGER_TRIG])
				sw_reset_trigger_armed <= 1'b1;
			else if (rd && widx == `ADDR_SW_RESET_TRIGGER && sw_reset_trigger_armed)
				sw_reset_trigger_armed <= 1'b0;
			SW_RESET_OUT <= rd && widx == `ADDR_SW_RESET_TRIGGER && sw_reset_trigger_armed;
			// Single NMI request for any flag, plus a pulse for software NMI
			NMI_REQ_OUT      <= |(next_nmi & `NMI_FLAG_MASK) | sw_nmi;
			SW_NMI_PULSE_OUT <= sw_nmi;
			SLEEP_WAKE_OUT   <= WDT_SLEEP_EVT_IN;
			// Reset counter: load on a new counting source, abandon on clear
			NMI_RESET_OUT <= 1'b0;
			// Reload taken from the value being stored, so a write that sets
			// the flag and the reload together counts with the new reload
			if (cnt_new && !count_run) begin
				nmi_count <= next_nmi[`NMI_CNT_MSB:0];
				count_run <= (next_nmi[`NMI_CNT_MSB:0] != 16'h0000);
				if (next_nmi[`NMI_CNT_MSB:0] == 16'h0000)
					NMI_RESET_OUT <= 1'b1;
			end else if (count_run) begin
				if (!cnt_src) begin
					count_run <= 1'b0;
				end else if (nmi_count == 16'h0001) begin
					nmi_count     <= 16'h0000;
					count_run     <= 1'b0;
					NMI_RESET_OUT <= 1'b1;
				end else begin
					nmi_count <= nmi_count - 16'h0001;
				end
			end
			SYS_RESET_OUT <= (rd && widx == `ADDR_SW_RESET_TRIGGER && sw_reset_trigger_armed)
				| (count_run && cnt_src && nmi_count == 16'h0001)
				| (cnt_new && !count_run && next_nmi[`NMI_CNT_MSB:0] == 16'h0000);
		end
	end

endmodule // reset_cause_and_nmi_control
`default_nettype wire

//--- verilog/reset_cause_map.vh
`ifndef RESET_CAUSE_MAP_VH
`define RESET_CAUSE_MAP_VH

// Word addresses on the register bus (byte address bits [3:2])
`define ADDR_CAUSE        2'h0
`define ADDR_SW_RESET_TRIGGER        2'h1
`define ADDR_NMICTL       2'h2
`define ADDR_UNLOCK       2'h3

// Unlock sequence keys, written in order to the unlock register
`define UNLOCK_KEY1       32'hAA996655
`define UNLOCK_KEY2       32'h556699AA

// Reset cause status field positions
`define CAUSE_IO_POR      31
`define CAUSE_CORE_POR    30
`define CAUSE_BOOT_CONFIG_VALUE_ERR    27
`define CAUSE_BOOT_CONFIG_VALUE_FAIL   26
`define CAUSE_NVM_LTA     25
`define CAUSE_NVM_EOL     24
`define CAUSE_BAT_POR     17
`define CAUSE_BAT_EXIT    16
`define CAUSE_DEEP_SLEEP  10
`define CAUSE_CFG_MISM    9
`define CAUSE_EXT_PIN     7
`define CAUSE_SW_RESET    6
`define CAUSE_DEADMAN     5
`define CAUSE_WATCHDOG    4
`define CAUSE_SLEEP       3
`define CAUSE_IDLE        2
`define CAUSE_BROWNOUT    1
`define CAUSE_POR         0
`define CAUSE_IMPL_MASK   32'hCF0306FF
`define CAUSE_RESET_VAL   32'h00000003

// Software reset trigger field
`define SW_RESET_TRIGGER_TRIG        0

// NMI control field positions
`define NMI_DEADMAN       25
`define NMI_WDT_RUN       24
`define NMI_SW_TRIG       23
`define NMI_GENERIC       19
`define NMI_LOW_VOLT      18
`define NMI_CLK_FAIL      17
`define NMI_WDT_SLEEP     16
`define NMI_CNT_MSB       15
`define NMI_FLAG_MASK     32'h030F0000
`define NMI_RESET_VAL     32'h00000000

`endif

//--- test/rcn_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module rcn_event_src (
	input  wire logic        clk_in,
	input  wire logic [22:0] fire_in,
	output var  logic [22:0] evt_out
);
	// Each source raises its event line one clock after fire_in, for as long as fire_in is held
	always_ff @(posedge clk_in) begin
		evt_out <= fire_in;
	end
endmodule // rcn_event_src
`default_nettype wire

//--- test/rcn_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcn_props (
	input wire CLOCK_IN,
	input wire RST_IN,
	input wire WB_CYC_IN,
	input wire WB_STB_IN,
	input wire WB_ACK_OUT,
	input wire DEADMAN_NMI_EVT_IN,
	input wire WDT_RUN_NMI_EVT_IN,
	input wire GENERIC_NMI_EVT_IN,
	input wire LOW_VOLT_EVT_IN,
	input wire CLK_FAIL_EVT_IN,
	input wire WDT_SLEEP_EVT_IN,
	input wire NMI_REQ_OUT,
	input wire SW_NMI_PULSE_OUT,
	input wire SLEEP_WAKE_OUT,
	input wire SYS_RESET_OUT,
	input wire SW_RESET_OUT,
	input wire NMI_RESET_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	// Bus answer and event to request relations
	AST_ACK: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
		else $error("ack not a single cycle after request");
	AST_EXT_NMI: assert property (GENERIC_NMI_EVT_IN || LOW_VOLT_EVT_IN |-> ##[1:2] NMI_REQ_OUT)
		else $error("generic or low voltage event gave no nmi");
	AST_CLK_NMI: assert property (CLK_FAIL_EVT_IN |-> ##[1:2] NMI_REQ_OUT)
		else $error("clock fail gave no nmi");
	AST_DMT_NMI: assert property (DEADMAN_NMI_EVT_IN |-> ##[1:2] NMI_REQ_OUT)
		else $error("deadman event gave no nmi");
	AST_WDR_NMI: assert property (WDT_RUN_NMI_EVT_IN |-> ##[1:2] NMI_REQ_OUT)
		else $error("watchdog run event gave no nmi");
	AST_WAKE: assert property (WDT_SLEEP_EVT_IN |=> SLEEP_WAKE_OUT)
		else $error("sleep timeout gave no wake");
	AST_SW_NMI_TRIGGER: assert property (SW_NMI_PULSE_OUT |=> !SW_NMI_PULSE_OUT)
		else $error("software nmi pulse too long");
	AST_SW_RESET_TRIGGER: assert property (SW_RESET_OUT |-> SYS_RESET_OUT ##1 !SW_RESET_OUT)
		else $error("software reset not a system reset pulse");
	AST_NMIRST: assert property (NMI_RESET_OUT |-> SYS_RESET_OUT && NMI_REQ_OUT)
		else $error("nmi reset without pending nmi");
	AST_SYS: assert property (SYS_RESET_OUT |-> SW_RESET_OUT || NMI_RESET_OUT)
		else $error("system reset without a cause");
endmodule // rcn_props
`default_nettype wire

//--- test/reset_cause_and_nmi_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_map.vh"
module reset_cause_and_nmi_control_tb;
	logic        clk, rst, cyc, stb, we;
	logic [3:0]  adr;
	logic [31:0] wdat, q;
	logic [22:0] fire;
	wire  [22:0] evt;
	wire  [31:0] rdat;
	wire         ack;
	wire  [6:0]  o;
	int          err_count, tests_run, cnt[7];
	int          pos[17] = '{31, 30, 27, 26, 25, 24, 17, 16, 10, 9, 7, 5, 4, 3, 2, 1, 0};
	rcn_event_src src (.clk_in(clk), .fire_in(fire), .evt_out(evt));
	reset_cause_and_nmi_control dut (.CLOCK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IO_POR_EVT_IN(evt[0]), .CORE_POR_EVT_IN(evt[1]),
		.BOOT_CFG_ERR_EVT_IN(evt[2]), .BOOT_CFG_FAIL_EVT_IN(evt[3]), .NVM_LTA_EVT_IN(evt[4]),
		.NVM_EOL_EVT_IN(evt[5]), .BAT_POR_EVT_IN(evt[6]), .BAT_EXIT_EVT_IN(evt[7]),
		.DEEP_SLEEP_EVT_IN(evt[8]), .CFG_MISMATCH_EVT_IN(evt[9]), .EXT_PIN_RESET_EVT_IN(evt[10]),
		.DEADMAN_RESET_EVT_IN(evt[11]), .WATCHDOG_RESET_EVT_IN(evt[12]),
		.SLEEP_WAKE_EVT_IN(evt[13]), .IDLE_WAKE_EVT_IN(evt[14]), .BROWNOUT_EVT_IN(evt[15]),
		.POR_EVT_IN(evt[16]), .DEADMAN_NMI_EVT_IN(evt[17]), .WDT_RUN_NMI_EVT_IN(evt[18]),
		.GENERIC_NMI_EVT_IN(evt[19]), .LOW_VOLT_EVT_IN(evt[20]), .CLK_FAIL_EVT_IN(evt[21]),
		.WDT_SLEEP_EVT_IN(evt[22]), .NMI_REQ_OUT(o[0]), .SW_NMI_PULSE_OUT(o[1]),
		.SLEEP_WAKE_OUT(o[2]), .SYS_RESET_OUT(o[3]), .SW_RESET_OUT(o[4]),
		.NMI_RESET_OUT(o[5]), .UNLOCKED_OUT(o[6]));
	// Clock and per-output counters of cycles spent high
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		for (int k = 0; k < 7; k++)
			cnt[k] <= cnt[k] + o[k];
	end
	task automatic end_sim;
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 20) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic unlock;
		wb(1'b1, 4'hC, `UNLOCK_KEY1);
		wb(1'b1, 4'hC, `UNLOCK_KEY2);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		fire <= 23'h1 << i;
		@(posedge clk);
		fire <= 23'h0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		{rst, cyc, stb, we, adr, wdat, fire} = '1;
		{cyc, stb, we, adr, wdat, fire} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(4'h0, `CAUSE_RESET_VAL);
		rd(4'h8, `NMI_RESET_VAL);
		wb(1'b1, 4'h0, 32'h0);
		for (int i = 0; i < 17; i++) begin
			pulse(i);
			rd(4'h0, 32'h1 << pos[i]);
			wb(1'b1, 4'h0, 32'h0);
		end
		wb(1'b1, 4'h0, `CAUSE_IMPL_MASK);
		rd(4'h0, `CAUSE_IMPL_MASK);
		wb(1'b1, 4'h8, 32'h0200_0005);
		wb(1'b1, 4'h4, 32'h1);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		chk(cnt[3], 0);
		unlock();
		wb(1'b1, 4'h8, 32'h0200_0005);
		repeat (2) @(posedge clk);
		chk(cnt[5], 0);
		repeat (10) @(posedge clk);
		chk(cnt[5], 1);
		rd(4'h8, 32'h0200_0005);
		chk(o[0], 1'b1);
		unlock();
		wb(1'b1, 4'h8, 32'h1E);
		pulse(18);
		rd(4'h8, 32'h0100_001E);
		unlock();
		wb(1'b1, 4'h8, 32'h1E);
		repeat (40) @(posedge clk);
		chk(cnt[5], 1);
		chk(o[0], 1'b0);
		unlock();
		wb(1'b1, 4'h8, 32'h0);
		pulse(17);
		chk(cnt[5], 2);
		for (int i = 19; i < 23; i++) begin
			unlock();
			wb(1'b1, 4'h8, 32'h0);
			pulse(i);
			rd(4'h8, 32'h1 << (38 - i));
			chk(o[0], 1'b1);
		end
		chk(cnt[2], 1);
		unlock();
		wb(1'b1, 4'h8, 32'h0008_0000);
		chk(o[0], 1'b1);
		unlock();
		wb(1'b1, 4'h8, 32'h0080_0000);
		repeat (2) @(posedge clk);
		chk(cnt[1], 1);
		wb(1'b1, 4'h0, 32'h0);
		unlock();
		wb(1'b1, 4'h4, 32'h1);
		chk(cnt[4], 0);
		rd(4'h4, 32'h0);
		repeat (2) @(posedge clk);
		chk(cnt[4], 1);
		rd(4'h0, 32'h0000_0040);
		rd(4'h4, 32'h0);
		repeat (3) @(posedge clk);
		chk(cnt[4], 1);
		end_sim();
	end
endmodule // reset_cause_and_nmi_control_tb
bind reset_cause_and_nmi_control rcn_props u_props (.CLOCK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN,
	.WB_ACK_OUT, .DEADMAN_NMI_EVT_IN, .WDT_RUN_NMI_EVT_IN, .GENERIC_NMI_EVT_IN, .LOW_VOLT_EVT_IN,
	.CLK_FAIL_EVT_IN, .WDT_SLEEP_EVT_IN, .NMI_REQ_OUT, .SW_NMI_PULSE_OUT, .SLEEP_WAKE_OUT,
	.SYS_RESET_OUT, .SW_RESET_OUT, .NMI_RESET_OUT);
`default_nettype wire
